/* File: rtl/eepw_top.sv */
`timescale 1ns/10ps
module eepw_top
    import eepw_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic CLK_SYS, // cpu clock
    input wire logic SYS_RST, // synchronous reset, high
    input wire eepw_xreq_type XD_REQ, // external data move request
    input wire logic INSTR_DONE, // pulse at each instruction end
    input wire logic CTRL_WR, // write to eeprom_ctrl_reg
    input wire logic [7:0] CTRL_WDATA, // data for eeprom_ctrl_reg
    input wire logic FLASH_SEL, // flash_latch_select_bit
    output logic [7:0] XD_RDATA, // read data, one cycle after rd
    output eepw_route_type XD_ROUTE, // target of current access
    output logic [7:0] CTRL_RDATA, // eeprom_ctrl_reg read view
    output logic BUSY // eeprom_prog_busy_flag
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] ee_mem [EE_BYTES];
    logic [7:0] col_latch [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] marker;
    logic [ROW_W-1:0] prog_row;
    logic eeprom_select_bit;
    logic armed;
    eepw_state_type state;
    logic [31:0] prog_cnt;
    logic [COL_W-1:0] prog_col;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire in_range = (XD_REQ.addr >= EE_BASE) && (XD_REQ.addr <= EE_LAST);
    // (R16) flash priority
    wire flash_hit = FLASH_SEL;
    // (R1) window select gate
    wire ee_hit = !flash_hit && eeprom_select_bit && in_range;
    wire busy = (state == ST_PROG);
    wire [ROW_W-1:0] req_row = XD_REQ.addr[EE_ADDR_W-1:COL_W];
    wire [COL_W-1:0] req_col = XD_REQ.addr[COL_W-1:0];
    wire [EE_ADDR_W-1:0] req_ee = XD_REQ.addr[EE_ADDR_W-1:0];
    // (R7) latch load decode; loads during programming are ignored
    wire load = ee_hit && XD_REQ.wr && !busy;
    // (R9) row change drops earlier bytes
    wire row_change = load && (req_row != prog_row);
    wire [3:0] seq = CTRL_WDATA[CTRL_SEQ_LO+3:CTRL_SEQ_LO];
    // (R10) second unlock value launches
    wire launch = CTRL_WR && armed && (seq == SEQ_SECOND) && !busy;
    wire prog_done = busy && (prog_cnt == 32'(PROG_CYCLES - 1));
    wire prog_step = busy && (prog_cnt < 32'(PAGE_BYTES));
    wire [EE_ADDR_W-1:0] prog_addr = {prog_row, prog_col};

    // (R17) unselected range to ram
    assign XD_ROUTE = flash_hit ? ROUTE_FLASH :
        (ee_hit ? ROUTE_EEPROM : ROUTE_RAM);
    // (R11) busy view
    assign BUSY = busy;
    assign CTRL_RDATA = {{(8-CTRL_BUSY_BIT-1){1'b0}}, busy,
        eeprom_select_bit};

    // ----------------------------------------------------------------
    // control register and unlock sequence
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            eeprom_select_bit <= CTRL_RESET[CTRL_SEL_BIT];
            armed <= 1'b0;
        end else if (CTRL_WR) begin
            eeprom_select_bit <= CTRL_WDATA[CTRL_SEL_BIT];
            armed <= (seq == SEQ_FIRST);
        end else if (INSTR_DONE) begin
            // (R13) intervening instruction aborts
            armed <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // programming sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state <= ST_IDLE;
            prog_cnt <= 32'h0000_0000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    prog_cnt <= 32'h0000_0000;
                    // (R11) busy set at launch
                    if (launch) begin
                        state <= ST_PROG;
                    end
                end
                ST_PROG: begin
                    prog_cnt <= prog_cnt + 32'h0000_0001;
                    // (R12) busy cleared at end
                    if (prog_done) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign prog_col = prog_cnt[COL_W-1:0];

    // ----------------------------------------------------------------
    // column latches and markers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            prog_row <= '0;
        end else if (load) begin
            // (R9) most recent row kept
            prog_row <= req_row;
        end
    end

    // one generate entry per page byte keeps the marker logic flat
    genvar gi;
    generate
        for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_col
            // (R6) low seven bits pick byte
            wire hit_col = load && (req_col == COL_W'(gi));
            always_ff @(posedge CLK_SYS) begin
                if (SYS_RST) begin
                    marker[gi] <= 1'b0;
                end else if (hit_col) begin
                    // (R5) marker set on load
                    marker[gi] <= 1'b1;
                end else if (row_change || prog_done) begin
                    // (R5) markers cleared after row
                    marker[gi] <= 1'b0;
                end
            end
            always_ff @(posedge CLK_SYS) begin
                if (hit_col) begin
                    col_latch[gi] <= XD_REQ.wdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // array write and read
    // ----------------------------------------------------------------
    // one byte per cycle during the first page-size cycles of
    // programming; the rest of the programming time is idle wait
    always_ff @(posedge CLK_SYS) begin
        // (R3) latch to row transfer
        // (R4) only marked bytes programmed
        if (prog_step && marker[prog_col]) begin
            ee_mem[prog_addr] <= col_latch[prog_col];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            XD_RDATA <= BLOCKED_READ;
        end else if (ee_hit && XD_REQ.rd) begin
            // (R11) reads blocked while busy
            // (R2) array read
            XD_RDATA <= busy ? BLOCKED_READ : ee_mem[req_ee];
        end
    end

endmodule

/* File: rtl/eepw_pkg.sv */
// What this block does
// (R1) EEPROM spans 0000h-07FFh when select set
// (R2) reads in range return EEPROM contents
// (R3) write: load latches, then program row
// (R4) program only latched bytes, 1 to 128
// (R5) marker per latch byte, cleared after programming
// (R6) address: 4 row bits, 7 byte bits
// (R7) selected write in range loads column latch
// (R8) software keeps one row between sessions
// (R9) last loaded row wins, other rows dropped
// (R10) 50h then A0h launches programming
// (R11) busy set at start, reads blocked
// (R12) busy cleared when row programming ends
// (R13) other instruction between unlock writes aborts
// (R14) software disables interrupts around accesses
// (R15) read: select, load pointer, then move
// (R16) flash latch select beats EEPROM select
// (R17) unselected accesses in range go to RAM
package eepw_pkg;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int EE_ADDR_W = 11;
    localparam int ROW_W = 4;
    localparam int COL_W = 7;
    localparam int PAGE_BYTES = 128;
    localparam int EE_BYTES = 2048;
    localparam logic [ADDR_W-1:0] EE_BASE = 16'h0000;
    localparam logic [ADDR_W-1:0] EE_LAST = 16'h07FF;

    // ----------------------------------------------------------------
    // control register layout
    // ----------------------------------------------------------------
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int CTRL_SEQ_LO = 4;
    localparam logic [3:0] SEQ_FIRST = 4'h5;
    localparam logic [3:0] SEQ_SECOND = 4'hA;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BLOCKED_READ = 8'hFF;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int PROG_TIME_US = 10_000;
    localparam int PROG_CYCLES_DEF =
        (PROG_TIME_US * (CLK_HZ / 1_000_000) < PAGE_BYTES) ? PAGE_BYTES :
        PROG_TIME_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } eepw_xreq_type;

    typedef enum logic [1:0] {
        ROUTE_RAM,
        ROUTE_EEPROM,
        ROUTE_FLASH
    } eepw_route_type;

    typedef enum logic {
        ST_IDLE,
        ST_PROG
    } eepw_state_type;

endpackage

/* File: tb/eepw_top_assertions.sv */
`timescale 1ns/10ps
module eepw_chk
    import eepw_pkg::*;
#(
    parameter int PROG_CYCLES = 200
) (
    input wire logic CLK_SYS, // cpu clock
    input wire logic SYS_RST, // sync reset
    input wire eepw_xreq_type XD_REQ, // move request
    input wire logic INSTR_DONE, // instruction end
    input wire logic CTRL_WR, // ctrl write
    input wire logic [7:0] CTRL_WDATA, // ctrl data
    input wire logic FLASH_SEL, // flash latch select
    input wire logic [7:0] XD_RDATA, // read data
    input wire eepw_route_type XD_ROUTE, // route
    input wire logic [7:0] CTRL_RDATA, // ctrl view
    input wire logic BUSY // busy flag
);
    localparam int PL = PROG_CYCLES - 1;
    wire sel = CTRL_RDATA[CTRL_SEL_BIT];
    wire in_ee = XD_REQ.addr <= EE_LAST;
    wire wr_a = CTRL_WR && CTRL_WDATA[7:4] == SEQ_SECOND;
    wire wr_5 = CTRL_WR && CTRL_WDATA[7:4] == SEQ_FIRST;
    wire lone = INSTR_DONE && !CTRL_WR;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // ----------------------------------------------------------------
    // routing and programming checks
    // ----------------------------------------------------------------
    a_flash_wins: assert property (FLASH_SEL |-> XD_ROUTE == ROUTE_FLASH)
        else $error("flash select lost priority");
    a_ram_unsel: assert property (!sel && !FLASH_SEL |-> XD_ROUTE == ROUTE_RAM)
        else $error("unselected access not routed to ram");
    a_ee_range: assert property (sel && !FLASH_SEL |-> (XD_ROUTE == ROUTE_EEPROM) == in_ee)
        else $error("eeprom range decode wrong");
    a_unlock_start: assert property (wr_a && $past(wr_5, 2) && !$past(INSTR_DONE) && !BUSY |=> BUSY)
        else $error("unlock pair did not start programming");
    a_unlock_abort: assert property (wr_a && $past(lone, 2) && !BUSY |=> !BUSY)
        else $error("programming started after interruption");
    a_busy_len: assert property ($rose(BUSY) |-> ##PL BUSY ##1 !BUSY)
        else $error("busy length wrong");
    a_read_blocked: assert property (BUSY && XD_REQ.rd && sel && !FLASH_SEL && in_ee |=> XD_RDATA == BLOCKED_READ)
        else $error("read not blocked while busy");
    a_ctrl_view: assert property (CTRL_RDATA[7:2] == 6'h00 && CTRL_RDATA[CTRL_BUSY_BIT] == BUSY)
        else $error("status view disagrees with busy");
endmodule
bind eepw_top eepw_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk(.CLK_SYS, .SYS_RST,
    .XD_REQ, .INSTR_DONE, .CTRL_WR, .CTRL_WDATA, .FLASH_SEL, .XD_RDATA,
    .XD_ROUTE, .CTRL_RDATA, .BUSY);

/* File: tb/eepw_cpu.sv */
`timescale 1ns/10ps
module eepw_cpu
    import eepw_pkg::*;
(
    input wire logic CLK_SYS, // cpu clock
    input wire logic [7:0] XD_RDATA, // read data
    output eepw_xreq_type XD_REQ, // move request
    output logic INSTR_DONE, // instruction end
    output logic CTRL_WR, // ctrl write
    output logic [7:0] CTRL_WDATA, // ctrl data
    output logic FLASH_SEL // flash latch select
);
    initial begin
        XD_REQ = '0;
        {INSTR_DONE, CTRL_WR, CTRL_WDATA, FLASH_SEL} = '0;
    end
    // ----------------------------------------------------------------
    // one instruction per call; released data shows the inverse
    // ----------------------------------------------------------------
    task automatic op(input logic [15:0] a, input logic [7:0] d,
        input logic r, input logic w, input logic c, input logic i);
        @(posedge CLK_SYS);
        #1;
        XD_REQ = '{addr: a, wdata: d, rd: r, wr: w};
        {CTRL_WR, CTRL_WDATA, INSTR_DONE} = {c, d, i};
        @(posedge CLK_SYS);
        #1;
        XD_REQ = '{addr: a, wdata: ~d, rd: 1'b0, wr: 1'b0};
        {CTRL_WR, CTRL_WDATA, INSTR_DONE} = {1'b0, ~d, 1'b0};
    endtask
    // the flash latch select level is kept by the cpu model alone
    task automatic fsel(input logic f);
        @(posedge CLK_SYS);
        #1;
        FLASH_SEL = f;
    endtask
    // interrupts stay off: any op with INSTR_DONE set and no ctrl write, ld and rd included, cuts into a sequence
    // each unlock write is a whole instruction
    task automatic ctl(input logic [7:0] d);
        op(16'h0000, d, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    // caller keeps one row per session unless dropping on purpose
    task automatic ld(input logic [15:0] a, input logic [7:0] d);
        op(a, d, 1'b0, 1'b1, 1'b0, 1'b1);
    endtask
    // pointer loaded, then move into accumulator
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        op(a, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
        @(posedge CLK_SYS);
        #1;
        d = XD_RDATA;
    endtask
endmodule

/* File: tb/eepw_top_bench.sv */
`timescale 1ns/10ps
module eepw_top_bench;
    import eepw_pkg::*;
    localparam int PC = 200;
    logic CLK_SYS, SYS_RST, INSTR_DONE, CTRL_WR, FLASH_SEL, BUSY;
    logic [7:0] CTRL_WDATA, XD_RDATA, CTRL_RDATA, v;
    eepw_xreq_type XD_REQ;
    eepw_route_type XD_ROUTE;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    eepw_top #(.PROG_CYCLES(PC)) DUT(.CLK_SYS, .SYS_RST, .XD_REQ, .INSTR_DONE,
        .CTRL_WR, .CTRL_WDATA, .FLASH_SEL, .XD_RDATA, .XD_ROUTE,
        .CTRL_RDATA, .BUSY);
    eepw_cpu cpu(.CLK_SYS, .XD_RDATA, .XD_REQ, .INSTR_DONE, .CTRL_WR,
        .CTRL_WDATA, .FLASH_SEL);
    initial begin
        CLK_SYS = 0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    task automatic chk(input string n, input logic [7:0] e, s);
        n_compared++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a read issued while busy must come back blocked
    task automatic prog(input logic peek);
        cpu.ctl(8'h51);
        cpu.ctl(8'hA1);
        @(posedge CLK_SYS);
        #1;
        chk("busy", 1, BUSY);
        if (peek) cpu.rd(16'h0181, v);
        if (peek) chk("blocked", BLOCKED_READ, v);
        for (int k = 0; k < PC + 10 && BUSY !== 1'b0; k++) begin
            @(posedge CLK_SYS);
            #1;
        end
        chk("busy end", 0, BUSY);
    endtask
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict;
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        SYS_RST = 1;
        repeat (16) @(posedge CLK_SYS);
        #1;
        SYS_RST = 0;
        chk("busy", 0, BUSY);
        chk("rdata", BLOCKED_READ, XD_RDATA);
        chk("ctrl", CTRL_RESET, CTRL_RDATA);
        cpu.fsel(1'b1);
        cpu.ctl(8'h01);
        chk("route", ROUTE_FLASH, XD_ROUTE);
        cpu.fsel(1'b0);
        cpu.op(16'h0800, 8'h00, 0, 0, 0, 0);
        chk("route", ROUTE_RAM, XD_ROUTE);
        cpu.op(16'h07FF, 8'h00, 0, 0, 0, 0);
        chk("route", ROUTE_EEPROM, XD_ROUTE);
        cpu.ld(16'h0105, 8'h44);
        prog(0);
        for (int i = 0; i < PAGE_BYTES; i++) begin
            cpu.ld(16'(16'h0180 + i), 8'(i ^ 8'h3C));
        end
        prog(0);
        cpu.ld(16'h0105, 8'h11);
        cpu.ld(16'h0181, 8'h77);
        prog(1);
        cpu.rd(16'h0105, v);
        chk("row 2 byte 5", 8'h44, v);
        cpu.rd(16'h0181, v);
        chk("row 3 byte 1", 8'h77, v);
        cpu.rd(16'h0180, v);
        chk("row 3 byte 0", 8'h3C, v);
        cpu.rd(16'h01FF, v);
        chk("row 3 byte 127", 8'h43, v);
        cpu.ctl(8'h51);
        cpu.op(16'h0000, 8'h00, 0, 0, 0, 1);
        cpu.ctl(8'hA1);
        @(posedge CLK_SYS);
        #1;
        chk("busy abort", 0, BUSY);
        cpu.ctl(8'h00);
        cpu.op(16'h0005, 8'h00, 0, 0, 0, 0);
        chk("route", ROUTE_RAM, XD_ROUTE);
        give_verdict;
    end
endmodule
